// [test_watch_lcd_clock_select.sv]
/* bench of wlcs_top: keyed writes, reads, clock rates.
   assumes wlcs_cpu as the bus side. */
`timescale 1ns/1ns
`include "wlcs_map.svh"
module test_watch_lcd_clock_select;
	localparam logic [31:0] ca = `WLCS_CFG_ADDR;
	logic clk = 1'b0, sys_rst = 1'b1, ce = 1'b0;
	logic [1:0] tk = 2'h0;
	logic [7:0] q, nl, nw;
	int err_total = 0, n_tests = 0, cyc = 0;
	wire logic [31:0] a;
	wire logic [7:0] wd, rd, cfg;
	wire logic w, r, b, pe, lc, wc;
	always #50 clk = ~clk;
	// internal tick every 2nd cycle, sub every 4th, main every cycle
	always @(negedge clk) tk <= tk + 2'h1;
	wlcs_cpu cpu (.clk, .bus_rdata(rd), .bus_addr(a), .bus_wr(w), .bus_rd(r),
		.bus_byte(b), .bus_wdata(wd));
	wlcs_top dut (.clk, .sys_rst, .bus_addr(a), .bus_wr(w), .bus_rd(r),
		.bus_byte(b), .bus_wdata(wd), .clr_err(ce), .int_tick(tk[0]),
		.sub_tick(&tk), .main_tick(1'b1), .bus_rdata(rd), .prot_err(pe),
		.cfg_out(cfg), .lcd_clock(lc), .watch_timer_clock(wc));
	task automatic chk(input logic [7:0] s, e);
		n_tests++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// settle 20 cycles, then count enables over 64
	task automatic rate(input logic [7:0] el, ew);
		{nl, nw} = 16'h0000;
		repeat (20) @(negedge clk);
		repeat (64) begin
			@(negedge clk);
			{nl, nw} = {nl + {7'h00, lc}, nw + {7'h00, wc}};
		end
		chk(nl, el);
		chk(nw, ew);
	endtask
	task automatic rst_rd;
		sys_rst = 1'b1;
		repeat (10) @(negedge clk);
		sys_rst = 1'b0;
		cpu.xfer(1'b0, ca, 8'h00, q);
		chk(q, 8'h00);
	endtask
	always @(posedge clk) if (++cyc == 2000) begin
		err_total++;
		complete_run;
	end
	initial begin
		rst_rd;
		// reset value: internal source, no division
		rate(8'h20, 8'h20);
		cpu.xfer(1'b1, ca, 8'h11, q); // unkeyed write
		cpu.xfer(1'b0, ca, 8'h00, q);
		chk(q, 8'h00);
		chk({7'h00, pe}, 8'h01);
		@(negedge clk) ce = 1'b1;
		@(negedge clk) ce = 1'b0;
		// keyed but not byte wide: no hit, so a violation
		cpu.byte_acc = 1'b0;
		cpu.prot_wr(8'h55);
		cpu.byte_acc = 1'b1;
		cpu.xfer(1'b0, ca, 8'h00, q);
		chk(q, 8'h00);
		chk({7'h00, pe}, 8'h01);
		@(negedge clk) ce = 1'b1;
		@(negedge clk) ce = 1'b0;
		chk({7'h00, pe}, 8'h00);
		cpu.prot_wr(8'hAB); // main source, code 2, halved
		cpu.prot_wr(8'h00); // dropped: already written
		cpu.xfer(1'b0, ca, 8'h00, q);
		chk(q, 8'h23);
		chk(cfg, 8'h23);
		chk({7'h00, pe}, 8'h00);
		$display("write once test done");
		rate(8'h10, 8'h08);
		rst_rd;
		cpu.prot_wr(8'h14); // sub source, code 1
		cpu.xfer(1'b0, ca, 8'h00, q);
		chk(q, 8'h14);
		chk(cfg, 8'h14);
		rate(8'h08, 8'h08);
		$display("clock rate test done");
		complete_run;
	end
endmodule

// [wlcs_chk.sv]
/* port assertions of wlcs_top.
   assumes bind below; sync reset high. */
`timescale 1ns/1ns
`include "wlcs_map.svh"
module wlcs_chk (
	input wire logic        clk,       // clock
	input wire logic        sys_rst,   // reset
	input wire logic [31:0] bus_addr,  // address
	input wire logic        bus_wr,    // write
	input wire logic        bus_rd,    // read
	input wire logic        bus_byte,  // byte access
	input wire logic [7:0]  bus_wdata, // write data
	input wire logic        clr_err,   // error clear
	input wire logic [7:0]  bus_rdata, // read data
	input wire logic        prot_err,  // error flag
	input wire logic [7:0]  cfg_out    // register
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// byte write to the register, and the key write before it
	wire logic cw = bus_wr && bus_addr == `WLCS_CFG_ADDR && bus_byte;
	wire logic kw = bus_wr && bus_addr == `WLCS_PROT_CMD_ADDR
		&& bus_wdata == `WLCS_PROT_KEY;
	logic armed_q; // last write was a fresh key
	logic once_q;  // a sequenced write has already landed
	// a key arms only when not armed, any write while armed ends the sequence; the bus
	// leaves cycles between writes, so $past of a write misses it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			armed_q <= 1'b0;
			once_q <= 1'b0;
		end else begin
			if (bus_wr) begin
				armed_q <= kw && !armed_q;
			end
			if (cw && armed_q) begin
				once_q <= 1'b1;
			end
		end
	end
	chk_rsvd_zero: assert property (!cfg_out[7] && !cfg_out[3])
		else $error("reserved bit set");
	chk_rst_clear: assert property (disable iff (1'b0)
		sys_rst |=> cfg_out == 8'h00) else $error("reset missed");
	chk_unseq_err: assert property (
		cw && !armed_q |=> prot_err)
		else $error("violation not flagged");
	chk_seq_quiet: assert property (
		armed_q && cw && !prot_err |=> !prot_err)
		else $error("good sequence flagged");
	chk_once_only: assert property (
		$changed(cfg_out) |-> $past(cw && armed_q && !once_q))
		else $error("register changed twice");
	chk_cfg_value: assert property (
		cw && armed_q && !once_q
		|=> cfg_out == ($past(bus_wdata) & `WLCS_CFG_WMASK))
		else $error("written value not stored");
	chk_read_data: assert property (
		bus_rd && bus_addr == `WLCS_CFG_ADDR && bus_byte
		|=> bus_rdata == $past(cfg_out)) else $error("bad read");
	chk_err_sticky: assert property (prot_err && !clr_err |=> prot_err)
		else $error("error flag dropped");
	chk_rd_idle: assert property (!bus_rd |=> bus_rdata == 8'h00)
		else $error("read data without read");
endmodule
bind wlcs_top wlcs_chk u_chk (.clk, .sys_rst, .bus_addr, .bus_wr, .bus_rd,
	.bus_byte, .bus_wdata, .clr_err, .bus_rdata, .prot_err, .cfg_out);

// [wlcs_cpu.sv]
/* cpu model: byte reads and keyed writes.
   assumes the bench calls its tasks. */
`timescale 1ns/1ns
`include "wlcs_map.svh"
module wlcs_cpu (
	input wire logic [7:0] bus_rdata, // read data
	input wire logic       clk,       // clock
	output logic [31:0]    bus_addr,  // address
	output logic           bus_wr,    // write
	output logic           bus_rd,    // read
	output logic           bus_byte,  // byte access
	output logic [7:0]     bus_wdata  // write data
);
	logic byte_acc = 1'b1; // bench may force a non-byte access
	initial {bus_addr, bus_wr, bus_rd, bus_byte, bus_wdata} = '0;
	// one strobe cycle; released lines scrambled so stale values never match
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge clk);
		{bus_wr, bus_rd, bus_addr, bus_wdata, bus_byte} = {w, !w, a, d,
			byte_acc};
		@(negedge clk);
		q = bus_rdata;
		{bus_wr, bus_rd, bus_addr, bus_wdata} = {2'b00, ~a, ~d};
	endtask
	// key first, and never both source bits; sub source only while
	// sub ticks run, and no stop mode is entered in this model
	task automatic prot_wr(input logic [7:0] d);
		logic [7:0] q;
		xfer(1'b1, `WLCS_PROT_CMD_ADDR, `WLCS_PROT_KEY, q);
		xfer(1'b1, `WLCS_CFG_ADDR, d[2] ? d & 8'hFE : d, q);
	endtask
endmodule

// [wlcs_divider.sv]
/*
 * power-of-two enable divider: emits a one-cycle enable per
 * 2^div ticks of src_tick, and a half-rate enable beside it.
 * assumes src_tick is a one-cycle pulse on clk.
 */
`timescale 1ns/1ns
module wlcs_divider
	import wlcs_pkg::*;
(
	input  wire logic                   clk,      // system clock
	input  wire logic                   sys_rst,  // sync reset, high
	input  wire logic                   src_tick, // source enable
	input  wire logic [`WLCS_DIV_W-1:0] div,      // log2 of ratio
	output logic                        lcd_en,   // lcd clock enable
	output logic                        half_en   // lcd enable / 2
);
	typedef struct packed {
		logic [`WLCS_CNT_W-1:0] cnt;
		logic                   tog;
		logic                   lcd;
		logic                   half;
	} wlcs_div_st_type;
	wlcs_div_st_type st_q, st_d;
	logic [`WLCS_CNT_W-1:0] lim;

	// limit is ratio minus one; code 0 passes every tick
	always_comb begin
		lim = (`WLCS_CNT_W'(1) << div) - `WLCS_CNT_W'(1);
		st_d = st_q;
		st_d.lcd = 1'b0;
		st_d.half = 1'b0;
		if (src_tick) begin
			if (st_q.cnt >= lim) begin
				st_d.cnt = '0;
				st_d.lcd = 1'b1;
				st_d.tog = ~st_q.tog;
				st_d.half = st_q.tog;
			end else begin
				st_d.cnt = st_q.cnt + `WLCS_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign lcd_en = st_q.lcd;
	assign half_en = st_q.half;
endmodule

// [wlcs_map.svh]
/*
 * constants of the watch / lcd clock configuration block:
 * register address, field positions, reset value, codes.
 * assumes inclusion by bare name from the package and modules.
 */
`ifndef WLCS_MAP_SVH
`define WLCS_MAP_SVH
`define WLCS_CFG_ADDR      32'hFFFFF836
`define WLCS_PROT_CMD_ADDR 32'hFFFFF800
`define WLCS_PROT_STS_ADDR 32'hFFFFF802
`define WLCS_PROT_KEY      8'hA5
`define WLCS_CFG_RESET     8'h00
`define WLCS_CFG_WMASK     8'h77
`define WLCS_DIV_LSB       4
`define WLCS_DIV_MSB       6
`define WLCS_SRC_OPT_BIT   2
`define WLCS_HALF_BIT      1
`define WLCS_SRC_SEL_BIT   0
`define WLCS_DIV_W         3
`define WLCS_CNT_W         8
`endif

// [wlcs_pkg.sv]
/*
 * types of the watch / lcd clock configuration block.
 * assumes wlcs_map.svh is on the include path.
 */
`include "wlcs_map.svh"
package wlcs_pkg;
	// source codes as {source_option_bit, source_select_bit}
	typedef enum logic [1:0] {
		WLCS_SRC_INTERNAL = 2'h0,
		WLCS_SRC_MAIN     = 2'h1,
		WLCS_SRC_SUB      = 2'h2,
		WLCS_SRC_BAD      = 2'h3
	} wlcs_src_type;
	// protection sequence states, gray along the usual path
	typedef enum logic [1:0] {
		WLCS_P_IDLE  = 2'h0,
		WLCS_P_ARMED = 2'h1
	} wlcs_prot_type;
	typedef struct packed {
		logic [31:0] addr;
		logic        wr;
		logic        rd;
		logic [7:0]  wdata;
	} wlcs_bus_type;
	typedef struct packed {
		logic [`WLCS_DIV_W-1:0] div;
		logic                   half;
		wlcs_src_type           src;
	} wlcs_cfg_type;
endpackage

// [wlcs_top.sv]
/*
 * watch / lcd clock configuration register with protected,
 * write-once access, plus the enable divider it steers.
 * assumes oscillator ticks are one-cycle pulses already on clk
 * and that the cpu bus is synchronous to clk.
 */
// Summary of operation
// - config register is eight bits, accessed as whole byte only
// - only one accepted write after power-on or external reset
// - writes need the key sequence; a broken sequence sets error
// - sequenced write after lock is dropped, error stays zero
// - error flag marks sequence violations only, not repeats
// - register clears to 00 only on power-on or external reset
// - bits 7 and 3 read zero; writes to them ignored
// - bits 6..4 divide the source by two to the code
// - bit 1 set halves the watch clock relative to lcd clock
// - bits 2 and 0 pick internal, sub or main source
`timescale 1ns/1ns
module wlcs_top
	import wlcs_pkg::*;
(
	input  wire logic       clk,         // 10 MHz system clock
	input  wire logic       sys_rst,     // poc or external reset
	input  wire logic [31:0] bus_addr,   // byte address
	input  wire logic       bus_wr,      // write strobe
	input  wire logic       bus_rd,      // read strobe
	input  wire logic       bus_byte,    // access is 8-bit wide
	input  wire logic [7:0] bus_wdata,   // write data
	input  wire logic       clr_err,     // clear error, from status
	input  wire logic       int_tick,    // internal osc tick
	input  wire logic       sub_tick,    // sub osc tick
	input  wire logic       main_tick,   // main osc tick
	output logic [7:0]      bus_rdata,   // read data
	output logic            prot_err,    // protection_error_flag
	output logic [7:0]      cfg_out,     // register contents
	output logic            lcd_clock,   // lcd clock enable
	output logic            watch_timer_clock // watch clock enable
);
	typedef struct packed {
		logic [7:0]    cfg;
		logic          locked;
		logic          err;
		wlcs_prot_type prot;
		logic [7:0]    rdata;
		logic          tick;
		logic          lcd;
		logic          wt;
	} wlcs_st_type;
	wlcs_st_type st_q, st_d;
	wlcs_bus_type bus;
	wlcs_cfg_type cfg;
	logic lcd_en, half_en;
	logic hit_cfg, hit_cmd, hit_sts;

	assign bus = '{addr: bus_addr, wr: bus_wr, rd: bus_rd,
		wdata: bus_wdata};
	assign hit_cfg = (bus.addr == `WLCS_CFG_ADDR) && bus_byte;
	assign hit_cmd = (bus.addr == `WLCS_PROT_CMD_ADDR);
	assign hit_sts = (bus.addr == `WLCS_PROT_STS_ADDR);
	assign cfg.div = st_q.cfg[`WLCS_DIV_MSB:`WLCS_DIV_LSB];
	assign cfg.half = st_q.cfg[`WLCS_HALF_BIT];
	assign cfg.src = wlcs_src_type'({st_q.cfg[`WLCS_SRC_OPT_BIT],
		st_q.cfg[`WLCS_SRC_SEL_BIT]});

	// lcd/watch divider chain fed by the selected source
	wlcs_divider u_div (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.src_tick (st_q.tick),
		.div      (cfg.div),
		.lcd_en   (lcd_en),
		.half_en  (half_en)
	);

	// protection sequence, write-once lock, source mux, read port
	always_comb begin
		st_d = st_q;
		// source mux; prohibited code gives no clock at all
		case (cfg.src)
			WLCS_SRC_INTERNAL: st_d.tick = int_tick;
			WLCS_SRC_SUB:      st_d.tick = sub_tick;
			WLCS_SRC_MAIN:     st_d.tick = main_tick;
			default:           st_d.tick = 1'b0;
		endcase
		st_d.lcd = lcd_en;
		st_d.wt = cfg.half ? half_en : lcd_en;
		if (clr_err) begin
			st_d.err = 1'b0;
		end
		case (st_q.prot)
			WLCS_P_IDLE: begin
				if (bus.wr && hit_cmd && bus.wdata == `WLCS_PROT_KEY) begin
					st_d.prot = WLCS_P_ARMED;
				end else if (bus.wr && hit_cfg) begin
					st_d.err = 1'b1;
				end
			end
			WLCS_P_ARMED: begin
				// any write after the key ends the sequence
				if (bus.wr) begin
					st_d.prot = WLCS_P_IDLE;
					if (hit_cfg) begin
						// repeat writes are dropped silently
						if (!st_q.locked) begin
							st_d.cfg = bus.wdata & `WLCS_CFG_WMASK;
							st_d.locked = 1'b1;
						end
					end else begin
						st_d.err = 1'b1;
					end
				end
			end
			default: st_d.prot = WLCS_P_IDLE;
		endcase
		st_d.rdata = 8'h00;
		if (bus.rd && hit_cfg) begin
			st_d.rdata = st_q.cfg;
		end else if (bus.rd && hit_sts) begin
			st_d.rdata = {7'h00, st_q.err};
		end
	end

	// only poc or external reset lands here
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= '0;
			st_q.cfg <= `WLCS_CFG_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign bus_rdata = st_q.rdata;
	assign prot_err = st_q.err;
	assign cfg_out = st_q.cfg;
	assign lcd_clock = st_q.lcd;
	assign watch_timer_clock = st_q.wt;
endmodule
